/* verilog/pxc_pkg.sv */
// shared constants, field layouts and carriers for the extended capability register bank
package pxc_pkg;

  // ********************************
  // widths
  // ********************************
  localparam int ADDR_W = 12;
  localparam int ERR_IDX_W = 5;
  localparam int NUM_VC = 2;
  localparam int HDR_WORDS = 4;

  // ********************************
  // register byte addresses
  // ********************************
  localparam logic [ADDR_W-1:0] ADDR_MASK = 12'hFFC;
  localparam logic [ADDR_W-1:0] OFF_HL0 = 12'h11C;
  localparam logic [ADDR_W-1:0] OFF_HL1 = 12'h120;
  localparam logic [ADDR_W-1:0] OFF_HL2 = 12'h124;
  localparam logic [ADDR_W-1:0] OFF_HL3 = 12'h128;
  localparam logic [ADDR_W-1:0] OFF_SN_CAP = 12'h180;
  localparam logic [ADDR_W-1:0] OFF_SN_LO = 12'h184;
  localparam logic [ADDR_W-1:0] OFF_SN_HI = 12'h188;
  localparam logic [ADDR_W-1:0] OFF_VC_CAP = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_PVC1 = 12'h204;

  // ********************************
  // field values and reset values
  // ********************************
  localparam logic [15:0] SN_CAP_ID = 16'h0003;
  localparam logic [15:0] VC_CAP_ID = 16'h0002;
  localparam logic [3:0] CAP_VER = 4'h1;
  localparam logic [11:0] SN_NEXT_RST = 12'h200;
  localparam logic [11:0] VC_NEXT_RST = 12'h000;
  localparam logic [31:0] SERIAL_RST = 32'h0000_0000;
  localparam logic [31:0] HL_RST = 32'h0000_0000;
  localparam logic [2:0] EXTRA_CH_CNT = 3'h1;
  localparam logic [2:0] LOW_PRIO_CNT = 3'h0;
  localparam logic [1:0] ARB_TIME_BASE = 2'h0;
  localparam logic [1:0] ENTRY_1BIT = 2'h0;
  localparam logic [1:0] ENTRY_2BIT = 2'h1;
  localparam logic [1:0] ENTRY_4BIT = 2'h2;
  localparam logic [1:0] ENTRY_8BIT = 2'h3;

  // ********************************
  // bus answers
  // ********************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // extended capability header layout
  typedef struct packed {
    logic [11:0] next_capability_pointer;
    logic [3:0] capability_version;
    logic [15:0] capability_identifier;
  } pxc_cap_hdr_t;

  // port vc capability one layout
  typedef struct packed {
    logic [19:0] rsvd_hi;
    logic [1:0] port_arb_entry_size;
    logic [1:0] arb_time_base;
    logic rsvd_7;
    logic [2:0] low_prio_channel_count;
    logic rsvd_3;
    logic [2:0] extra_channel_count;
  } pxc_pvc_t;

  // logged packet header, word 0 is the first doubleword
  typedef logic [HDR_WORDS-1:0][31:0] pxc_hdr_t;

  // one register write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } pxc_wr_t;

endpackage : pxc_pkg

/* verilog/pxc_axil_slave.sv */
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/10ps
module pxc_axil_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [pxc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output pxc_pkg::pxc_wr_t wr,
  output logic wr_en,
  input wire logic wr_hit,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [pxc_pkg::ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q, next_rdata;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;

  // ready while nothing is held; the response stalls new writes
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en = aw_held && w_held && !s_axi_bvalid;
  assign wr = '{addr: awaddr_q, data: wdata_q, strb: wstrb_q};

  // channel bookkeeping; address and data may come in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (wr_en) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? pxc_pkg::RESP_OKAY : pxc_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // read data is frozen at the address handshake
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = rd_hit ? pxc_pkg::RESP_OKAY : pxc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // registers of the bus front end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pxc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pxc_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule : pxc_axil_slave

/* verilog/pxc_err_log.sv */
// sticky first-error header log and first error index
`timescale 1ns/10ps
module pxc_err_log (
  // clock and power-on reset
  input wire logic aclk,
  input wire logic por_n,
  // error report
  input wire logic err_valid,
  input wire logic [pxc_pkg::ERR_IDX_W-1:0] err_index,
  input wire pxc_pkg::pxc_hdr_t err_header,
  input wire logic err_status_clear,
  // logged state
  output pxc_pkg::pxc_hdr_t hdr_log,
  output logic [pxc_pkg::ERR_IDX_W-1:0] first_error_index,
  output logic err_logged
);
  pxc_pkg::pxc_hdr_t next_hdr_log;
  logic [pxc_pkg::ERR_IDX_W-1:0] next_first_error_index;
  logic next_err_logged;

  // capture only into an empty log; a new error beats a clear in the same cycle
  always_comb begin
    next_hdr_log = hdr_log;
    next_first_error_index = first_error_index;
    next_err_logged = err_logged;
    if (err_status_clear) begin
      next_err_logged = 1'b0;
    end
    if (err_valid && (!err_logged || err_status_clear)) begin
      next_hdr_log = err_header;
      next_first_error_index = err_index;
      next_err_logged = 1'b1;
    end
  end

  // sticky: only power-on reset clears it
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      hdr_log <= {pxc_pkg::HDR_WORDS{pxc_pkg::HL_RST}};
      first_error_index <= '0;
      err_logged <= 1'b0;
    end else begin
      hdr_log <= next_hdr_log;
      first_error_index <= next_first_error_index;
      err_logged <= next_err_logged;
    end
  end
endmodule : pxc_err_log

/* verilog/pxc_regs.sv */
// extended capability register bank: error header log, serial number, virtual channel
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// ********************************
// ********************************
module pxc_regs #(
  parameter int NUM_VC = pxc_pkg::NUM_VC
) (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // axi4-lite write channels
  input wire logic [pxc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [pxc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // lock control for the lock-writable fields
  input wire logic cfg_unlock,
  // uncorrectable error report
  input wire logic err_valid,
  input wire logic [pxc_pkg::ERR_IDX_W-1:0] err_index,
  input wire pxc_pkg::pxc_hdr_t err_header,
  input wire logic err_status_clear,
  // virtual channel arbitration
  input wire logic [NUM_VC-1:0] vc_req,
  output logic [NUM_VC-1:0] vc_grant,
  // state seen by the rest of the port
  output logic [63:0] serial_id,
  output logic [pxc_pkg::ERR_IDX_W-1:0] first_error_index,
  output logic err_logged
);

  // ********************************
  // helpers
  // ********************************

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // true for every word of this bank, writable or not
  function automatic logic addr_hit(input logic [pxc_pkg::ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr & pxc_pkg::ADDR_MASK)
      pxc_pkg::OFF_HL0, pxc_pkg::OFF_HL1, pxc_pkg::OFF_HL2, pxc_pkg::OFF_HL3,
      pxc_pkg::OFF_SN_CAP, pxc_pkg::OFF_SN_LO, pxc_pkg::OFF_SN_HI,
      pxc_pkg::OFF_VC_CAP, pxc_pkg::OFF_PVC1: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : addr_hit

  // ********************************
  // bus front end and error log
  // ********************************
  pxc_pkg::pxc_wr_t wr;
  logic wr_en;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [31:0] wr_data;
  pxc_pkg::pxc_hdr_t hdr_log;

  pxc_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr(wr),
    .wr_en(wr_en),
    .wr_hit(wr_hit),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // first error wins; the log stays until the status is cleared
  pxc_err_log u_log (
    .aclk(aclk),
    .por_n(por_n),
    .err_valid(err_valid),
    .err_index(err_index),
    .err_header(err_header),
    .err_status_clear(err_status_clear),
    .hdr_log(hdr_log),
    .first_error_index(first_error_index),
    .err_logged(err_logged)
  );

  // ********************************
  // writable fields
  // ********************************
  logic [31:0] serial_lo, serial_hi, next_serial_lo, next_serial_hi;
  logic [11:0] sn_next, vc_next, next_sn_next, next_vc_next;
  pxc_pkg::pxc_cap_hdr_t sn_hdr, vc_hdr, sn_merged, vc_merged;
  pxc_pkg::pxc_pvc_t pvc1;

  assign wr_hit = addr_hit(wr.addr);
  assign wr_data = wr.data;
  assign serial_id = {serial_hi, serial_lo};

  // fixed header fields around the writable next pointers
  assign sn_hdr = '{next_capability_pointer: sn_next, capability_version: pxc_pkg::CAP_VER,
                    capability_identifier: pxc_pkg::SN_CAP_ID};
  assign vc_hdr = '{next_capability_pointer: vc_next, capability_version: pxc_pkg::CAP_VER,
                    capability_identifier: pxc_pkg::VC_CAP_ID};
  assign sn_merged = merge(sn_hdr, wr.data, wr.strb);
  assign vc_merged = merge(vc_hdr, wr.data, wr.strb);

  // port vc capability one is constant
  assign pvc1 = '{rsvd_hi: '0, rsvd_7: 1'b0, rsvd_3: 1'b0,
                  extra_channel_count: pxc_pkg::EXTRA_CH_CNT,
                  low_prio_channel_count: pxc_pkg::LOW_PRIO_CNT,
                  arb_time_base: pxc_pkg::ARB_TIME_BASE,
                  port_arb_entry_size: pxc_pkg::ENTRY_4BIT};

  // lock-writable fields change only while unlocked; locked writes still answer okay
  always_comb begin
    next_serial_lo = serial_lo;
    next_serial_hi = serial_hi;
    next_sn_next = sn_next;
    next_vc_next = vc_next;
    if (wr_en && cfg_unlock) begin
      case (wr.addr & pxc_pkg::ADDR_MASK)
        pxc_pkg::OFF_SN_LO: next_serial_lo = merge(serial_lo, wr.data, wr.strb);
        pxc_pkg::OFF_SN_HI: next_serial_hi = merge(serial_hi, wr.data, wr.strb);
        pxc_pkg::OFF_SN_CAP: next_sn_next = sn_merged.next_capability_pointer;
        pxc_pkg::OFF_VC_CAP: next_vc_next = vc_merged.next_capability_pointer;
        default: next_sn_next = sn_next;
      endcase
    end
  end

  // serial number is sticky: a warm reset leaves it alone
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      serial_lo <= pxc_pkg::SERIAL_RST;
      serial_hi <= pxc_pkg::SERIAL_RST;
    end else begin
      serial_lo <= next_serial_lo;
      serial_hi <= next_serial_hi;
    end
  end

  // next pointers return to default on any reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !por_n) begin
      sn_next <= pxc_pkg::SN_NEXT_RST;
      vc_next <= pxc_pkg::VC_NEXT_RST;
    end else begin
      sn_next <= next_sn_next;
      vc_next <= next_vc_next;
    end
  end

  // ********************************
  // read decode
  // ********************************

  // unmapped words read zero and answer slverr
  always_comb begin
    rd_hit = addr_hit(s_axi_araddr);
    case (s_axi_araddr & pxc_pkg::ADDR_MASK)
      pxc_pkg::OFF_HL0: rd_data = hdr_log[0];
      pxc_pkg::OFF_HL1: rd_data = hdr_log[1];
      pxc_pkg::OFF_HL2: rd_data = hdr_log[2];
      pxc_pkg::OFF_HL3: rd_data = hdr_log[3];
      pxc_pkg::OFF_SN_CAP: rd_data = sn_hdr;
      pxc_pkg::OFF_SN_LO: rd_data = serial_lo;
      pxc_pkg::OFF_SN_HI: rd_data = serial_hi;
      pxc_pkg::OFF_VC_CAP: rd_data = vc_hdr;
      pxc_pkg::OFF_PVC1: rd_data = pvc1;
      default: rd_data = '0;
    endcase
  end

  // ********************************
  // strict priority channel arbiter
  // ********************************
  logic [NUM_VC-1:0] next_vc_grant;

  // no low-priority group, so the highest requesting channel always wins
  always_comb begin
    next_vc_grant = '0;
    for (int i = 0; i < NUM_VC; i++) begin
      if (vc_req[i]) begin
        next_vc_grant = '0;
        next_vc_grant[i] = 1'b1;
      end
    end
  end

  // grant is registered to keep it glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vc_grant <= '0;
    end else begin
      vc_grant <= next_vc_grant;
    end
  end

  // ********************************
  // assertions
  // ********************************
  pxc_pkg::pxc_cap_hdr_t rd_cap;
  pxc_pkg::pxc_pvc_t rd_pvc;
  logic log_empty_hit;

  assign rd_cap = s_axi_rdata;
  assign rd_pvc = s_axi_rdata;
  assign log_empty_hit = err_valid && !err_logged;

  // a read of one word answered on the next cycle
  sequence s_read(logic [pxc_pkg::ADDR_W-1:0] a);
    s_axi_arvalid && s_axi_arready && ((s_axi_araddr & pxc_pkg::ADDR_MASK) == a) ##1 s_axi_rvalid;
  endsequence

  // an unlocked full-word write to one word
  sequence s_write(logic [pxc_pkg::ADDR_W-1:0] a);
    wr_en && cfg_unlock && ((wr.addr & pxc_pkg::ADDR_MASK) == a) && (wr.strb == 4'hF);
  endsequence

  a_log_capture: assert property (@(posedge aclk) disable iff (!por_n)
    log_empty_hit |=> (hdr_log == $past(err_header)) && err_logged)
    else $error("header log missed the first error");
  a_sn_header: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read(pxc_pkg::OFF_SN_CAP) |-> rd_cap.capability_identifier == pxc_pkg::SN_CAP_ID
    && rd_cap.next_capability_pointer == $past(sn_next, 1))
    else $error("serial header id or pointer wrong");
  a_cap_version: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_read(pxc_pkg::OFF_SN_CAP) or s_read(pxc_pkg::OFF_VC_CAP)) |-> rd_cap.capability_version == pxc_pkg::CAP_VER)
    else $error("capability version wrong");
  a_serial_low: assert property (@(posedge aclk) disable iff (!por_n)
    s_write(pxc_pkg::OFF_SN_LO) |=> serial_lo == $past(wr_data) ##1 $stable(serial_lo) || wr_en)
    else $error("serial low word not loaded");
  a_serial_high: assert property (@(posedge aclk) disable iff (!por_n)
    s_write(pxc_pkg::OFF_SN_HI) |=> serial_id[63:32] == $past(wr_data))
    else $error("serial high word not loaded");
  a_vc_cap_id: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read(pxc_pkg::OFF_VC_CAP) |-> rd_cap.capability_identifier == pxc_pkg::VC_CAP_ID)
    else $error("vc capability id wrong");
  a_vc_next_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(aresetn) |-> vc_next == pxc_pkg::VC_NEXT_RST) and (wr_en && !cfg_unlock |=> $stable(vc_next)))
    else $error("vc next pointer default or lock broken");
  a_extra_count: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read(pxc_pkg::OFF_PVC1) |-> rd_pvc.extra_channel_count == pxc_pkg::EXTRA_CH_CNT)
    else $error("extra channel count wrong");
  a_strict_prio: assert property (@(posedge aclk) disable iff (!aresetn)
    vc_req[NUM_VC-1] |=> vc_grant[NUM_VC-1] && $onehot(vc_grant) && pvc1.low_prio_channel_count == pxc_pkg::LOW_PRIO_CNT)
    else $error("highest channel not granted");
  a_time_base: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read(pxc_pkg::OFF_PVC1) |-> rd_pvc.arb_time_base == pxc_pkg::ARB_TIME_BASE)
    else $error("arbitration time base wrong");
  a_entry_size: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read(pxc_pkg::OFF_PVC1) |-> rd_pvc.port_arb_entry_size == pxc_pkg::ENTRY_4BIT)
    else $error("arbitration entry size wrong");
  a_first_index: assert property (@(posedge aclk) disable iff (!por_n)
    log_empty_hit |=> first_error_index == $past(err_index))
    else $error("first error index not captured");
  a_sticky_keep: assert property (@(posedge aclk) disable iff (!por_n)
    !aresetn |=> $stable(serial_id) && $stable(hdr_log))
    else $error("sticky field lost on warm reset");
  a_log_hold: assert property (@(posedge aclk) disable iff (!por_n)
    err_logged && !err_status_clear |=> $stable(hdr_log) && $stable(first_error_index))
    else $error("logged header overwritten");

endmodule : pxc_regs

/* sim/pxc_host_model.sv */
// axi4-lite host model standing in for configuration software
`timescale 1ns/10ps
module pxc_host_model (
  // clock
  input wire logic aclk,
  // write channels
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // byte enables of the next write; full word unless a test narrows it
  logic [3:0] strb_sel = 4'hF;
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // one write; readies sampled mid cycle so each edge decision is race free
  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    bh = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb_sel;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      // released payload is scrambled, never left looking valid
      if (ah) s_axi_awvalid <= 1'b0;
      if (ah) s_axi_awaddr <= ~a;
      if (wh) s_axi_wvalid <= 1'b0;
      if (wh) s_axi_wdata <= ~d;
      if (bh) s_axi_bready <= 1'b0;
    end
  endtask : wr
  // one read
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    rh = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (ah) s_axi_araddr <= ~a;
      if (rh) s_axi_rready <= 1'b0;
    end
  endtask : rd
endmodule : pxc_host_model

/* sim/tb_top.sv */
// self-checking bench for the extended capability register bank
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  // ********************************
  // signals and expected state
  // ********************************
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, cfg_unlock = 1'b0, err_valid = 1'b0, err_status_clear = 1'b0;
  logic [4:0] err_index = '0, first_error_index, m_idx;
  pxc_pkg::pxc_hdr_t err_header = '0, m_hdr;
  logic [1:0] vc_req = '0, vc_grant, s_axi_bresp, s_axi_rresp, r;
  logic [63:0] serial_id;
  logic err_logged, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr, m_snp, m_vcp;
  logic [31:0] s_axi_wdata, s_axi_rdata, m_lo, m_hi, d32;
  logic [3:0] s_axi_wstrb;
  logic [11:0] offs [10];
  int mismatches = 0, samples_checked = 0;
  // 50 ns clock
  always #25 aclk = ~aclk;
  pxc_regs #(.NUM_VC(2)) dut (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cfg_unlock, .err_valid, .err_index, .err_header, .err_status_clear, .vc_req, .vc_grant, .serial_id,
    .first_error_index, .err_logged);
  pxc_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // expected word at an offset; pvc word is ext count 1, entry size 4-bit, rest zero
  function automatic logic [31:0] exp_val(input logic [11:0] a);
    case (a)
      pxc_pkg::OFF_HL0: exp_val = m_hdr[0];
      pxc_pkg::OFF_HL1: exp_val = m_hdr[1];
      pxc_pkg::OFF_HL2: exp_val = m_hdr[2];
      pxc_pkg::OFF_HL3: exp_val = m_hdr[3];
      pxc_pkg::OFF_SN_CAP: exp_val = {m_snp, 4'h1, 16'h0003};
      pxc_pkg::OFF_SN_LO: exp_val = m_lo;
      pxc_pkg::OFF_SN_HI: exp_val = m_hi;
      pxc_pkg::OFF_VC_CAP: exp_val = {m_vcp, 4'h1, 16'h0002};
      pxc_pkg::OFF_PVC1: exp_val = 32'h00000801;
      default: exp_val = 32'h00000000;
    endcase
  endfunction : exp_val
  // read every word plus one unmapped word
  task chk_all();
    logic [31:0] d;
    for (int i = 0; i < 10; i++) begin
      host.rd(offs[i], d, r);
      `CHK(d, exp_val(offs[i]))
      `CHK(r, (i == 9) ? 2'h2 : 2'h0)
    end
  endtask : chk_all
  // warm or power-on reset held three cycles
  task do_reset(input logic por);
    @(posedge aclk);
    aresetn <= 1'b0;
    if (por) por_n <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    m_snp = 12'h200;
    m_vcp = 12'h000;
    if (por) {m_lo, m_hi, m_hdr, m_idx} = '0;
  endtask : do_reset
  // one error report pulse, optionally with a status clear
  task err_ev(input logic clr, input logic take);
    pxc_pkg::pxc_hdr_t h;
    logic [4:0] x;
    h = {$urandom, $urandom, $urandom, $urandom};
    x = 5'($urandom);
    @(posedge aclk);
    err_valid <= 1'b1;
    err_header <= h;
    err_index <= x;
    err_status_clear <= clr;
    @(posedge aclk);
    err_valid <= 1'b0;
    err_status_clear <= 1'b0;
    if (take) m_hdr = h;
    if (take) m_idx = x;
    chk_all();
    `CHK(first_error_index, m_idx)
    `CHK(err_logged, 1'b1)
  endtask : err_ev
  // verdict and end of run
  task test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end
  // ********************************
  // tests
  // ********************************
  initial begin
    offs = '{pxc_pkg::OFF_HL0, pxc_pkg::OFF_HL1, pxc_pkg::OFF_HL2, pxc_pkg::OFF_HL3, pxc_pkg::OFF_SN_CAP,
      pxc_pkg::OFF_SN_LO, pxc_pkg::OFF_SN_HI, pxc_pkg::OFF_VC_CAP, pxc_pkg::OFF_PVC1, 12'h12C};
    void'($urandom(32'hE9DA53E9));
    do_reset(1'b1);
    chk_all();
    $display("test reset_values done");
    // locked: every write answered, none lands
    for (int i = 0; i < 10; i++) begin
      host.wr(offs[i], $urandom, r);
      `CHK(r, (i == 9) ? 2'h2 : 2'h0)
    end
    chk_all();
    $display("test locked_writes done");
    // unlocked: only lock-writable fields move, id and version bits stay
    cfg_unlock <= 1'b1;
    {m_lo, m_hi, m_snp, m_vcp} = {$urandom, $urandom, 24'($urandom)};
    host.wr(pxc_pkg::OFF_SN_LO, m_lo, r);
    host.wr(pxc_pkg::OFF_SN_HI, m_hi, r);
    host.wr(pxc_pkg::OFF_SN_CAP, {m_snp, 20'hFFFFF}, r);
    host.wr(pxc_pkg::OFF_VC_CAP, {m_vcp, 20'hFFFFF}, r);
    host.wr(pxc_pkg::OFF_HL2, $urandom, r);
    // lanes 0 and 2 only: the other bytes keep the word just written
    d32 = $urandom;
    host.strb_sel = 4'h5;
    host.wr(pxc_pkg::OFF_SN_LO, d32, r);
    host.strb_sel = 4'hF;
    m_lo = {m_lo[31:24], d32[23:16], m_lo[15:8], d32[7:0]};
    cfg_unlock <= 1'b0;
    chk_all();
    `CHK(serial_id, {m_hi, m_lo})
    $display("test unlocked_writes done");
    // first error kept, second ignored, clear with new error captures it
    err_ev(1'b0, 1'b1);
    err_ev(1'b0, 1'b0);
    err_ev(1'b1, 1'b1);
    // a clear alone empties the log for the next error
    @(posedge aclk);
    err_status_clear <= 1'b1;
    @(posedge aclk);
    err_status_clear <= 1'b0;
    @(negedge aclk);
    `CHK(err_logged, 1'b0)
    err_ev(1'b0, 1'b1);
    $display("test error_log done");
    // warm reset keeps sticky state, power-on clears it
    do_reset(1'b0);
    chk_all();
    do_reset(1'b1);
    chk_all();
    `CHK(err_logged, 1'b0)
    $display("test resets done");
    // strict priority, highest channel wins
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      vc_req <= 2'(i);
      @(posedge aclk);
      @(negedge aclk);
      `CHK(vc_grant, (i > 1) ? 2'h2 : 2'(i))
    end
    $display("test arbiter done");
    test_done();
  end
endmodule : tb_top
